// ==== hdl/asp_consts.svh ====
// Register offsets, field positions, reset values and counts of the serial port.
// Assumes byte addresses on a 32-bit register bus, one register per aligned word.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
// Register byte offsets
`define ASP_OFF_TXCTL 8'h00
`define ASP_OFF_RXCTL 8'h04
`define ASP_OFF_BAUD 8'h08
`define ASP_OFF_TXDATA 8'h0C
`define ASP_OFF_RXBUF 8'h10
// Transmit control fields
`define ASP_B_CLKSRC 7
`define ASP_B_TXNINE 6
`define ASP_B_TRANSMIT_ENABLE 5
`define ASP_B_SYNC 4
`define ASP_B_HISPD 2
`define ASP_B_TXEMPTY 1
`define ASP_B_TXNINTH 0
// Receive control fields
`define ASP_B_PORTEN 7
`define ASP_B_RXNINE 6
`define ASP_B_SINGLE 5
`define ASP_B_CONT 4
`define ASP_B_ADDRDET 3
`define ASP_B_FRAMING_ERROR 2
`define ASP_B_OVR 1
`define ASP_B_RXNINTH 0
// Reset values
`define ASP_TXCTL_RST 8'h00
`define ASP_RXCTL_RST 8'h00
`define ASP_BAUD_RST 8'h00
// Oversampling and bit counts
`define ASP_OS_LAST 4'hF
`define ASP_VOTE_LO 4'h7
`define ASP_VOTE_HI 4'h9
`define ASP_LAST_BIT8 4'h7
`define ASP_LAST_BIT9 4'h8
`define ASP_LS_PRE_LAST 2'h3
// Bus responses
`define ASP_RESP_OKAY 2'h0
`define ASP_RESP_SLVERR 2'h2
`endif

// ==== hdl/asp_pkg.sv ====
// Types shared by the serial port: bus carriers, register select and states.
// Assumes an AXI4-Lite master with 32-bit data on the register side.
package asp_pkg;
	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} asp_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} asp_axi_rsp_t;
	typedef enum logic [2:0] {REG_TXCTL, REG_RXCTL, REG_BAUD, REG_TXDATA, REG_RXBUF, REG_NONE} asp_reg_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} asp_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asp_rx_st_t;
endpackage : asp_pkg

// ==== hdl/asp_baud_gen.sv ====
// Baud rate generator: free-running down counter plus prescaler.
// Assumes divisor and restart come from the register file on the same clock.
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_baud_gen #(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic run_i,
	input wire logic restart_i,
	input wire logic [DIV_W-1:0] divisor_i,
	input wire logic high_speed_i,
	// Ticks
	output logic os_tick_o,
	output logic half_tick_o
);
	logic [DIV_W-1:0] count;
	logic [1:0] pre;
	logic tick;

	generate
		if (DIV_W < 1 || DIV_W > 16) begin : g_chk
			$error("asp_baud_gen: DIV_W out of range");
		end
	endgenerate

	assign tick = run_i && (count == '0);

	// Down counter reloads on zero; a divisor write clears it so a new rate starts at once
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !run_i || restart_i) begin
			count <= '0;
		end else if (tick) begin
			count <= divisor_i;
		end else begin
			count <= count - 1'b1;
		end
	end

	// Prescaler: low speed needs four ticks per oversample, sync needs two per half bit
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !run_i || restart_i) begin
			pre <= 2'h0;
		end else if (tick) begin
			pre <= pre + 2'h1;
		end
	end

	// 16 oversamples per bit give 16(n+1) or 64(n+1); two half bits give 4(n+1)
	assign os_tick_o = tick && (high_speed_i || pre == `ASP_LS_PRE_LAST);
	assign half_tick_o = tick && pre[0];
endmodule : asp_baud_gen

// ==== hdl/asp_rx_vote.sv ====
// Majority detector: keeps the last three samples of the receive line.
// Assumes its input is already synchronised to clk_i.
`timescale 1ns/1ps
module asp_rx_vote (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Sampling
	input wire logic clear_i,
	input wire logic take_i,
	input wire logic din_i,
	// Decision
	output logic vote_o
);
	logic [2:0] samples;

	// Shift in one sample per strobe; idle level is high
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clear_i) begin
			samples <= 3'h7;
		end else if (take_i) begin
			samples <= {samples[1:0], din_i};
		end
	end

	// Two of three decide the level
	assign vote_o = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);
endmodule : asp_rx_vote

// ==== hdl/asp_top.sv ====
// Addressable serial port: registers on AXI4-Lite, async and sync serial engine.
// Assumes both pins meet a pad that resolves the level from the output enables.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_top #(
	parameter int ADDR_W = 8,
	parameter int DIV_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register bus
	input wire asp_pkg::asp_axi_req_t axi_req_i,
	output asp_pkg::asp_axi_rsp_t axi_rsp_o,
	// Transmit or shift clock pin
	input wire logic serial_out_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	// Receive or sync data pin
	input wire logic serial_in_pin_i,
	output logic serial_in_pin_o,
	output logic serial_in_pin_oe_o,
	// Status levels
	output logic rx_char_ready_o,
	output logic tx_hold_empty_o
);
	import asp_pkg::*;

	generate
		if (ADDR_W < 5 || ADDR_W > 32 || DIV_W != 8) begin : g_chk
			$error("asp_top: unsupported ADDR_W or DIV_W");
		end
	endgenerate

	// Register decode, shared by read and write paths
	function automatic asp_reg_t reg_of(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`ASP_OFF_TXCTL)) begin
			return REG_TXCTL;
		end else if (a == ADDR_W'(`ASP_OFF_RXCTL)) begin
			return REG_RXCTL;
		end else if (a == ADDR_W'(`ASP_OFF_BAUD)) begin
			return REG_BAUD;
		end else if (a == ADDR_W'(`ASP_OFF_TXDATA)) begin
			return REG_TXDATA;
		end else if (a == ADDR_W'(`ASP_OFF_RXBUF)) begin
			return REG_RXBUF;
		end
		return REG_NONE;
	endfunction : reg_of

	// Bus state
	logic aw_held, w_held, b_valid, r_valid, wr_fire, rd_take, w_lane0;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data, r_data;
	logic [1:0] b_resp, r_resp;
	asp_reg_t wr_reg, rd_reg;
	// Software-owned fields
	logic [7:0] tx_ctl, baud_divisor;
	logic port_enable, rx_nine_bit_select, single_receive_enable, continuous_receive_enable, address_detect_enable;
	// Serial engine state
	logic core_rst, sync_mode, sync_master, rx_req_sync, tx_allowed, rx_sync_on, sync_busy;
	logic os_tick, half_tick, vote, sclk, edge_rise, edge_fall, rx_take;
	logic ck_s1, ck_s2, ck_prev, dt_s1, dt_s2;
	logic [7:0] tx_hold;
	logic tx_hold_full, tx_shifter_empty;
	logic [8:0] tx_shift, rx_shift;
	logic [3:0] tx_bits, tx_os, rx_bits, rx_os, tx_last, rx_last;
	asp_tx_st_t tx_state;
	asp_rx_st_t rx_state;
	logic [7:0] receive_buffer;
	logic rx_full, framing_error, overrun_error, rx_ninth_bit;
	logic rx_done, rx_done_framing_error, rx_accept, rx_load, rx_pop;
	logic next_out_o, next_out_oe, next_in_o, next_in_oe;

	// Field views of transmit control
	wire clock_source_select = tx_ctl[`ASP_B_CLKSRC];
	wire tx_nine_bit_select = tx_ctl[`ASP_B_TXNINE];
	wire transmit_enable = tx_ctl[`ASP_B_TRANSMIT_ENABLE];
	wire high_speed_baud = tx_ctl[`ASP_B_HISPD];
	wire tx_ninth_bit = tx_ctl[`ASP_B_TXNINTH];

	// Write channel: address and data taken in either order, answer after both
	assign wr_reg = reg_of(aw_addr);
	assign wr_fire = aw_held && w_held && !b_valid;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			b_valid <= 1'b0;
			b_resp <= `ASP_RESP_OKAY;
			aw_addr <= '0;
			w_data <= 32'h00000000;
			w_lane0 <= 1'b0;
		end else begin
			if (axi_req_i.awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= axi_req_i.awaddr[ADDR_W-1:0];
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (axi_req_i.wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= axi_req_i.wdata;
				w_lane0 <= axi_req_i.wstrb[0];
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
			if (wr_fire) begin
				b_valid <= 1'b1;
				b_resp <= (wr_reg == REG_NONE) ? `ASP_RESP_SLVERR : `ASP_RESP_OKAY;
			end else if (axi_req_i.bready) begin
				b_valid <= 1'b0;
			end
		end
	end

	// Read channel: one read at a time, data registered
	assign rd_reg = reg_of(axi_req_i.araddr[ADDR_W-1:0]);
	assign rd_take = axi_req_i.arvalid && !r_valid;
	assign rx_pop = rd_take && (rd_reg == REG_RXBUF);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_valid <= 1'b0;
			r_data <= 32'h00000000;
			r_resp <= `ASP_RESP_OKAY;
		end else if (rd_take) begin
			r_valid <= 1'b1;
			r_resp <= (rd_reg == REG_NONE) ? `ASP_RESP_SLVERR : `ASP_RESP_OKAY;
			case (rd_reg)
				REG_TXCTL: r_data <= {24'h000000, tx_ctl[7:4], 1'b0, tx_ctl[2], tx_shifter_empty, tx_ctl[0]};
				REG_RXCTL: r_data <= {24'h000000, port_enable, rx_nine_bit_select, single_receive_enable,
					continuous_receive_enable, address_detect_enable, framing_error, overrun_error, rx_ninth_bit};
				REG_BAUD: r_data <= {24'h000000, baud_divisor};
				REG_RXBUF: r_data <= {24'h000000, receive_buffer};
				default: r_data <= 32'h00000000;
			endcase
		end else if (axi_req_i.rready) begin
			r_valid <= 1'b0;
		end
	end

	assign axi_rsp_o = '{awready: !aw_held, wready: !w_held, bvalid: b_valid, bresp: b_resp,
		arready: !r_valid, rvalid: r_valid, rdata: r_data, rresp: r_resp};

	// Control registers; the whole transmit control byte is stored, bit 1 reads back as shifter status
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tx_ctl <= `ASP_TXCTL_RST;
			baud_divisor <= `ASP_BAUD_RST;
		end else if (wr_fire && w_lane0) begin
			if (wr_reg == REG_TXCTL) begin
				tx_ctl <= w_data[7:0];
			end
			if (wr_reg == REG_BAUD) begin
				baud_divisor <= w_data[7:0];
			end
		end
	end

	// Receive control; a software write wins over the hardware clear of single receive
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			{port_enable, rx_nine_bit_select, single_receive_enable} <= 3'h0;
			{continuous_receive_enable, address_detect_enable} <= 2'h0;
		end else if (wr_fire && w_lane0 && wr_reg == REG_RXCTL) begin
			port_enable <= w_data[`ASP_B_PORTEN];
			rx_nine_bit_select <= w_data[`ASP_B_RXNINE];
			single_receive_enable <= w_data[`ASP_B_SINGLE];
			continuous_receive_enable <= w_data[`ASP_B_CONT];
			address_detect_enable <= w_data[`ASP_B_ADDRDET];
		end else if (rx_done && sync_master && !continuous_receive_enable) begin
			single_receive_enable <= 1'b0;
		end
	end

	// Mode decode
	assign core_rst = !rst_n_i || !port_enable;
	assign sync_mode = tx_ctl[`ASP_B_SYNC];
	assign sync_master = sync_mode && clock_source_select;
	assign rx_req_sync = continuous_receive_enable || (single_receive_enable && sync_master);
	assign tx_allowed = transmit_enable && !(sync_mode && rx_req_sync);
	assign rx_sync_on = sync_mode && rx_req_sync && !overrun_error && tx_state == TX_IDLE;
	assign sync_busy = sync_master && (tx_state == TX_DATA || rx_sync_on);
	assign tx_last = tx_nine_bit_select ? `ASP_LAST_BIT9 : `ASP_LAST_BIT8;
	assign rx_last = rx_nine_bit_select ? `ASP_LAST_BIT9 : `ASP_LAST_BIT8;
	assign tx_shifter_empty = (tx_state == TX_IDLE);

	asp_baud_gen #(.DIV_W(DIV_W)) u_baud (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.run_i(port_enable),
		.restart_i(wr_fire && w_lane0 && wr_reg == REG_BAUD),
		.divisor_i(baud_divisor),
		.high_speed_i(high_speed_baud && !sync_mode),
		.os_tick_o(os_tick),
		.half_tick_o(half_tick)
	);

	// Pin synchronisers; the second stage is used, plus a third stage on the clock pin to find its edges
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			{ck_s1, ck_s2, ck_prev, dt_s1, dt_s2} <= 5'h1F;
		end else begin
			ck_s1 <= serial_out_pin_i;
			ck_s2 <= ck_s1;
			ck_prev <= ck_s2;
			dt_s1 <= serial_in_pin_i;
			dt_s2 <= dt_s1;
		end
	end

	// Master shift clock idles low and toggles every half bit while busy
	always_ff @(posedge clk_i) begin
		if (core_rst || !sync_busy) begin
			sclk <= 1'b0;
		end else if (half_tick) begin
			sclk <= !sclk;
		end
	end

	// Sync edges come from our own clock as master or the pin as slave
	assign edge_rise = sync_master ? (half_tick && sync_busy && !sclk) : (ck_s2 && !ck_prev);
	assign edge_fall = sync_master ? (half_tick && sync_busy && sclk) : (!ck_s2 && ck_prev);

	// Holding register; a write in the same cycle as a load keeps it full
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			tx_hold <= 8'h00;
			tx_hold_full <= 1'b0;
		end else if (wr_fire && w_lane0 && wr_reg == REG_TXDATA) begin
			tx_hold <= w_data[7:0];
			tx_hold_full <= 1'b1;
		end else if (tx_state == TX_IDLE && tx_allowed) begin
			tx_hold_full <= 1'b0;
		end
	end

	// Transmitter: async frames use 16 oversamples per bit, sync shifts on falling edges
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			tx_state <= TX_IDLE;
			tx_shift <= 9'h1FF;
			tx_bits <= 4'h0;
			tx_os <= 4'h0;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					if (tx_hold_full && tx_allowed) begin
						tx_shift <= {tx_ninth_bit, tx_hold};
						tx_state <= sync_mode ? TX_DATA : TX_START;
						tx_bits <= 4'h0;
						tx_os <= 4'h0;
					end
				end
				TX_START: begin
					if (os_tick) begin
						tx_os <= tx_os + 4'h1;
						if (tx_os == `ASP_OS_LAST) begin
							tx_state <= TX_DATA;
						end
					end
				end
				TX_DATA: begin
					if (sync_mode ? edge_fall : (os_tick && tx_os == `ASP_OS_LAST)) begin
						tx_shift <= {1'b1, tx_shift[8:1]};
						tx_bits <= tx_bits + 4'h1;
						if (tx_bits == tx_last) begin
							tx_state <= sync_mode ? TX_IDLE : TX_STOP;
						end
					end
					if (os_tick && !sync_mode) begin
						tx_os <= tx_os + 4'h1;
					end
				end
				TX_STOP: begin
					if (os_tick) begin
						tx_os <= tx_os + 4'h1;
						if (tx_os == `ASP_OS_LAST) begin
							tx_state <= TX_IDLE;
						end
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// Majority samples at the middle three oversamples of each async bit
	assign rx_take = !sync_mode && rx_state != RX_IDLE && os_tick && rx_os >= `ASP_VOTE_LO && rx_os <= `ASP_VOTE_HI;

	asp_rx_vote u_vote (
		.clk_i(clk_i),
		.rst_n_i(!core_rst),
		.clear_i(rx_state == RX_IDLE),
		.take_i(rx_take),
		.din_i(dt_s2),
		.vote_o(vote)
	);

	// Receiver; it halts while an overrun is pending
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			rx_state <= RX_IDLE;
			rx_shift <= 9'h000;
			rx_bits <= 4'h0;
			rx_os <= 4'h0;
			rx_done <= 1'b0;
			rx_done_framing_error <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (sync_mode) begin
				rx_state <= RX_IDLE;
				rx_os <= 4'h0;
				if (!rx_sync_on) begin
					rx_bits <= 4'h0;
				end else if (edge_rise) begin
					rx_shift[rx_bits] <= dt_s2;
					rx_bits <= (rx_bits == rx_last) ? 4'h0 : rx_bits + 4'h1;
					rx_done <= (rx_bits == rx_last);
					rx_done_framing_error <= 1'b0;
				end
			end else begin
				if (os_tick) begin
					rx_os <= rx_os + 4'h1;
				end
				case (rx_state)
					RX_IDLE: begin
						rx_os <= 4'h0;
						rx_bits <= 4'h0;
						if (os_tick && !dt_s2 && continuous_receive_enable && !overrun_error) begin
							rx_state <= RX_START;
							rx_shift <= 9'h000;
						end
					end
					RX_START: begin
						if (os_tick && rx_os == `ASP_OS_LAST) begin
							rx_state <= vote ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (os_tick && rx_os == `ASP_OS_LAST) begin
							rx_shift[rx_bits] <= vote;
							rx_bits <= rx_bits + 4'h1;
							if (rx_bits == rx_last) begin
								rx_state <= RX_STOP;
							end
						end
					end
					RX_STOP: begin
						if (os_tick && rx_os == `ASP_OS_LAST) begin
							rx_state <= RX_IDLE;
							rx_done <= 1'b1;
							rx_done_framing_error <= !vote;
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// Address detect filters async nine-bit characters with a clear ninth bit
	assign rx_accept = sync_mode || !rx_nine_bit_select || !address_detect_enable
		|| rx_shift[8];
	assign rx_load = rx_done && rx_accept && (!rx_full || rx_pop);

	// Receive buffer with its error and ninth bit; a load wins over a read
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			receive_buffer <= 8'h00;
			rx_ninth_bit <= 1'b0;
			framing_error <= 1'b0;
			rx_full <= 1'b0;
		end else if (rx_load) begin
			receive_buffer <= rx_shift[7:0];
			rx_ninth_bit <= rx_nine_bit_select && rx_shift[8];
			framing_error <= rx_done_framing_error;
			rx_full <= 1'b1;
		end else if (rx_pop) begin
			rx_full <= 1'b0;
		end
	end

	// Overrun: a character arrives with the buffer still full; a set wins over the clear
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			overrun_error <= 1'b0;
		end else if (rx_done && rx_accept && rx_full && !rx_pop) begin
			overrun_error <= 1'b1;
		end else if (!continuous_receive_enable) begin
			overrun_error <= 1'b0;
		end
	end

	// Pin drive and direction chosen by mode
	always_comb begin
		next_out_o = 1'b1;
		next_out_oe = 1'b0;
		next_in_o = 1'b1;
		next_in_oe = 1'b0;
		if (!sync_mode) begin
			next_out_oe = 1'b1;
			next_out_o = (tx_state == TX_START) ? 1'b0 : (tx_state == TX_DATA) ? tx_shift[0] : 1'b1;
		end else begin
			next_out_oe = clock_source_select;
			next_out_o = sclk;
			next_in_oe = (tx_state == TX_DATA);
			next_in_o = tx_shift[0];
		end
	end

	// Registered pins; released to input while the port is off
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			{serial_out_pin_o, serial_out_pin_oe_o, serial_in_pin_o, serial_in_pin_oe_o} <= 4'hA;
		end else begin
			{serial_out_pin_o, serial_out_pin_oe_o} <= {next_out_o, next_out_oe};
			{serial_in_pin_o, serial_in_pin_oe_o} <= {next_in_o, next_in_oe};
		end
	end

	// Status levels
	assign rx_char_ready_o = rx_full;
	assign tx_hold_empty_o = !tx_hold_full;
endmodule : asp_top

// ==== tb/asp_chk.sv ====
// Checker: bus handshake and reset relations of the serial port.
// Assumes it is bound to asp_top and sees only that module's ports.
`timescale 1ns/1ps
module asp_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Watched ports
	input wire asp_pkg::asp_axi_req_t axi_req_i,
	input wire asp_pkg::asp_axi_rsp_t axi_rsp_o,
	input wire logic serial_out_pin_oe_o,
	input wire logic serial_in_pin_oe_o,
	input wire logic rx_char_ready_o,
	input wire logic tx_hold_empty_o
);
	import asp_pkg::*;
	// One domain, so one clock and one disable for all
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_bresp_hold: assert property (axi_rsp_o.bvalid && !axi_req_i.bready
		|=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp)) else $error("write response dropped");
	a_rdata_hold: assert property (axi_rsp_o.rvalid && !axi_req_i.rready
		|=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata)) else $error("read data dropped");
	a_write_answer: assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready
		|-> ##2 axi_rsp_o.bvalid) else $error("write answer late");
	a_aw_block: assert property (axi_req_i.awvalid && axi_rsp_o.awready |=> !axi_rsp_o.awready)
		else $error("address taken twice");
	a_read_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
		else $error("read answer late");
	a_arready_tie: assert property (axi_rsp_o.rvalid |-> !axi_rsp_o.arready) else $error("read accepted while busy");
	a_unmapped_rd: assert property (axi_req_i.arvalid && axi_rsp_o.arready && axi_req_i.araddr[7:0] > 8'h10
		|=> axi_rsp_o.rresp == 2'h2) else $error("unmapped read not refused");
	a_txctl_zero: assert property (axi_req_i.arvalid && axi_rsp_o.arready && axi_req_i.araddr[7:0] == 8'h00
		|=> axi_rsp_o.rdata[31:8] == 24'h000000 && !axi_rsp_o.rdata[3]) else $error("unused bits set");
	a_idle_release: assert property ($rose(rst_n_i) |-> !serial_out_pin_oe_o && !serial_in_pin_oe_o
		&& tx_hold_empty_o && !rx_char_ready_o) else $error("port not idle after reset");
endmodule : asp_chk
bind asp_top asp_chk u_asp_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o),
	.serial_out_pin_oe_o(serial_out_pin_oe_o), .serial_in_pin_oe_o(serial_in_pin_oe_o),
	.rx_char_ready_o(rx_char_ready_o), .tx_hold_empty_o(tx_hold_empty_o));

// ==== tb/asp_peer.sv ====
// Partner: far-end asynchronous serial device on the two pins.
// Assumes the bench sets bit time and character width before traffic.
`timescale 1ns/1ps
module asp_peer (
	// Clock
	input wire logic clk_i,
	// Line from the port; line into the port, the only pin driven here
	input wire logic line_i,
	output logic line_o
);
	int bt = 32;
	int nb = 8;
	int ng = 0;
	logic [8:0] got = 9'h000;
	// Mark level until a frame is sent
	initial line_o = 1'b1;
	// Start, data LSB first, stop; ninth bit sent raw, no parity added
	task send(input logic [8:0] d, input logic stp);
		line_o <= 1'b0;
		repeat (bt) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			line_o <= d[i];
			repeat (bt) @(posedge clk_i);
		end
		line_o <= stp;
		repeat (bt) @(posedge clk_i);
		line_o <= 1'b1;
		repeat (bt) @(posedge clk_i);
	endtask : send
	// Mid-bit sampling: a wrong bit rate shows up as wrong data
	initial begin
		forever begin
			@(negedge line_i);
			repeat (bt / 2) @(posedge clk_i);
			for (int i = 0; i < 9; i++) begin
				repeat (i < nb ? bt : 0) @(posedge clk_i);
				got[i] = i < nb ? line_i : 1'b0;
			end
			repeat (bt) @(posedge clk_i);
			ng++;
		end
	end
endmodule : asp_peer

// ==== tb/asp_top_tb.sv ====
// Bench: registers over AXI4-Lite, async traffic with the far-end peer, sync master transmit.
// Assumes the design files and asp_peer are compiled first.
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_top_tb;
	import asp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	asp_axi_req_t req = '0;
	asp_axi_rsp_t rsp;
	logic so, soe, sio, sioe, peer_tx, rdy, hemp;
	wire out_lvl = soe ? so : 1'b1; // Pull-up assumed on the released pin
	wire in_lvl = sioe ? sio : peer_tx;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int g;
	logic [31:0] rv;
	logic [1:0] rr;
	logic [8:0] d;
	asp_top u_asp_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .axi_req_i(req), .axi_rsp_o(rsp),
		.serial_out_pin_i(out_lvl), .serial_out_pin_o(so), .serial_out_pin_oe_o(soe), .serial_in_pin_i(in_lvl),
		.serial_in_pin_o(sio), .serial_in_pin_oe_o(sioe), .rx_char_ready_o(rdy), .tx_hold_empty_o(hemp));
	asp_peer u_asp_peer (.clk_i(clk_i), .line_i(out_lvl), .line_o(peer_tx));
	// 250 MHz clock
	initial forever #2 clk_i = ~clk_i;
	// Clocks per bit from speed bit and divisor
	function automatic int bclk(input logic hs, input int n);
		return (hs ? 16 : 64) * (n + 1);
	endfunction : bclk
	// Transmit control read-back: bit 3 zero, shifter empty while idle
	function automatic logic [31:0] txrd(input logic [7:0] v);
		return {24'h000000, (v & 8'hF5) | 8'h02};
	endfunction : txrd
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task give_verdict;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	// Write: both channels offered together, each released once taken
	task wr(input logic [7:0] a, input logic [7:0] v);
		logic ta, tw, da, dw;
		@(posedge clk_i);
		req.awvalid <= 1'b1;
		req.awaddr <= {24'h000000, a};
		req.wvalid <= 1'b1;
		req.wdata <= {24'h000000, v};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		da = 1'b0;
		dw = 1'b0;
		// Ready and valid are read at the rising edge, before the design's registers move
		while (!(da && dw)) begin
			@(posedge clk_i);
			ta = !da && rsp.awready;
			tw = !dw && rsp.wready;
			if (ta) req.awvalid <= 1'b0;
			if (tw) req.wvalid <= 1'b0;
			da = da || ta;
			dw = dw || tw;
		end
		do @(posedge clk_i); while (rsp.bvalid !== 1'b1);
		rr = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		req.arvalid <= 1'b1;
		req.araddr <= {24'h000000, a};
		req.rready <= 1'b1;
		do @(posedge clk_i); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge clk_i); while (rsp.rvalid !== 1'b1);
		rv = rsp.rdata;
		rr = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd
	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rv, e);
	endtask : rc
	// Hang guard, far above the expected run length
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 50000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(26677));
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rc(`ASP_OFF_TXCTL, 32'h00000002);
		rc(`ASP_OFF_RXCTL, 32'h00000000);
		rc(`ASP_OFF_BAUD, 32'h00000000);
		wr(`ASP_OFF_TXCTL, 8'hFF);
		chk(32'(rr), 32'(`ASP_RESP_OKAY));
		rc(`ASP_OFF_TXCTL, txrd(8'hFF));
		wr(8'h40, 8'h00);
		chk(32'(rr), 32'(`ASP_RESP_SLVERR));
		rc(8'h44, 32'h00000000);
		chk(32'(rr), 32'(`ASP_RESP_SLVERR));
		d = 9'($urandom);
		wr(`ASP_OFF_BAUD, d[7:0]);
		rc(`ASP_OFF_BAUD, {24'h000000, d[7:0]});
		// Both speeds, both widths: transmit then receive
		for (int k = 0; k < 4; k++) begin
			d = 9'($urandom);
			wr(`ASP_OFF_BAUD, 8'h01);
			// Mode first, so the port never wakes as a sync master and clocks the peer's line
			wr(`ASP_OFF_TXCTL, {1'b0, k[1], 1'b1, 2'b00, k[0], 1'b0, d[8]});
			wr(`ASP_OFF_RXCTL, {1'b1, k[1], 6'h10});
			u_asp_peer.bt = bclk(k[0], 1);
			u_asp_peer.nb = k[1] ? 9 : 8;
			g = u_asp_peer.ng;
			wr(`ASP_OFF_TXDATA, d[7:0]);
			wait (u_asp_peer.ng == g + 1);
			chk(32'(u_asp_peer.got), 32'(k[1] ? d : {1'b0, d[7:0]}));
			chk(32'(hemp), 32'h00000001);
			d = 9'($urandom);
			u_asp_peer.send(d, 1'b1);
			chk(32'(rdy), 32'h00000001);
			rc(`ASP_OFF_RXCTL, {24'h000000, 1'b1, k[1], 6'h10 | 6'(k[1] & d[8])});
			rc(`ASP_OFF_RXBUF, {24'h000000, d[7:0]});
		end
		// Address detect: ninth bit clear is dropped, set is kept
		wr(`ASP_OFF_RXCTL, 8'hD8);
		d = 9'($urandom);
		u_asp_peer.send({1'b0, d[7:0]}, 1'b1);
		chk(32'(rdy), 32'h00000000);
		u_asp_peer.send({1'b1, d[7:0]}, 1'b1);
		rc(`ASP_OFF_RXCTL, 32'h000000D9);
		rc(`ASP_OFF_RXBUF, {24'h000000, d[7:0]});
		// Overrun: second character lost, flag cleared by dropping continuous receive with the port left enabled
		wr(`ASP_OFF_RXCTL, 8'h90);
		u_asp_peer.nb = 8;
		u_asp_peer.send(9'h0A5, 1'b1);
		u_asp_peer.send(9'h03C, 1'b1);
		rc(`ASP_OFF_RXCTL, 32'h00000092);
		rc(`ASP_OFF_RXBUF, 32'h000000A5);
		wr(`ASP_OFF_RXCTL, 8'h80);
		wr(`ASP_OFF_RXCTL, 8'h90);
		rc(`ASP_OFF_RXCTL, 32'h00000090);
		// Framing error: a low stop bit may look like a new start afterwards
		d = 9'($urandom);
		u_asp_peer.send(d, 1'b0);
		rc(`ASP_OFF_RXCTL, 32'h00000094);
		rc(`ASP_OFF_RXBUF, {24'h000000, d[7:0]});
		// Sync master transmit: data and drive taken at each rising shift clock, period 4(n+1)
		wr(`ASP_OFF_RXCTL, 8'h80);
		wr(`ASP_OFF_TXCTL, 8'hB0);
		d = 9'($urandom);
		wr(`ASP_OFF_TXDATA, d[7:0]);
		for (int i = 0; i < 8; i++) begin
			@(posedge so);
			if (i == 0) g = cyc;
			rv[i] = sio;
			rv[i + 8] = sioe;
		end
		chk(32'(rv[15:0]), {16'h00FF, d[7:0]});
		chk(32'(cyc - g), 32'(7 * 4 * (1 + 1)));
		chk(32'(soe), 32'h00000001);
		give_verdict();
	end
endmodule : asp_top_tb
